// File: ssc_channel_sync.sv
`timescale 1ns/1ps
module ssc_channel_sync
    import ssc_pkg::*;
(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                arst_n,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Cyclic link
    input  wire logic                cycle_strobe,
    input  wire logic [7:0]          cpu_status_byte,
    input  wire logic [MTU_BITS-1:0] cpu_to_module_window,
    output logic      [7:0]          module_status_byte,
    output logic      [MTU_BITS-1:0] module_to_cpu_window
);
    logic                 rst_meta;
    logic                 rst_n;
    logic [SEQ_W-1:0]     cpu_tx_seq_count;
    logic                 cpu_tx_sync_request;
    logic [SEQ_W-1:0]     cpu_rx_seq_mirror;
    logic                 cpu_rx_sync_confirm;
    logic [SEQ_W-1:0]     module_rx_seq_mirror;
    logic                 module_rx_sync_confirm;
    logic [SEQ_W-1:0]     module_tx_seq_count;
    logic                 module_tx_sync_request;
    logic                 rx_synced;
    logic                 rx_new_seq;
    logic                 rx_start;
    logic                 rx_flush;
    logic [MTU_BITS-1:0]  rx_window;
    logic                 rx_busy;
    logic                 tx_synced;
    logic                 tx_send;
    logic                 tx_open;
    logic                 tx_go;
    logic [2:0]           tx_len;
    logic [47:0]          tx_data;
    logic [RAM_AW-1:0]    rx_index;
    logic                 rx_ready;
    logic [MSG_LEN_W-1:0] rx_len;
    logic                 df_wr_en;
    logic [RAM_AW-1:0]    df_wr_addr;
    logic [7:0]           df_wr_data;
    logic                 df_done;
    logic [MSG_LEN_W-1:0] df_len;
    logic [7:0]           ram_data;
    logic                 apb_access;
    logic                 apb_write;
    logic                 mapped;
    logic [31:0]          read_value;
    logic [7:0]           next_header;

    // Reset is released through two flops; everything else except the message RAM, which has no reset, uses rst_n.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // CPU status byte fields.
    assign cpu_tx_seq_count    = cpu_status_byte[ST_SEQ_LSB +: SEQ_W];
    assign cpu_tx_sync_request = cpu_status_byte[ST_SYNC_BIT];
    assign cpu_rx_seq_mirror   = cpu_status_byte[ST_MIR_LSB +: SEQ_W];
    assign cpu_rx_sync_confirm = cpu_status_byte[ST_CONF_BIT];

    // Module status byte is a plain gathering of flops.
    assign module_status_byte = {module_rx_sync_confirm, module_rx_seq_mirror,
                                 module_tx_sync_request, module_tx_seq_count};

    assign rx_synced  = module_rx_sync_confirm && cpu_tx_sync_request;
    assign rx_new_seq = (cpu_tx_seq_count == SEQ_W'(module_rx_seq_mirror + 1'b1));
    assign tx_synced  = module_tx_sync_request && cpu_rx_sync_confirm;
    assign tx_send    = cycle_strobe && tx_synced && tx_go && (cpu_rx_seq_mirror == module_tx_seq_count);

    // Output direction: mirror while closing, accept one window per new counter value.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            module_rx_seq_mirror   <= '0;
            module_rx_sync_confirm <= 1'b0;
            rx_start               <= 1'b0;
            rx_flush               <= 1'b0;
            rx_window              <= '0;
        end
        else
        begin
            rx_start <= 1'b0;
            rx_flush <= 1'b0;
            if (cycle_strobe && !rx_synced)
            begin
                // Window contents are not taken while the channel is closed.
                module_rx_seq_mirror   <= cpu_tx_seq_count;
                module_rx_sync_confirm <= cpu_tx_sync_request;
                rx_flush               <= 1'b1;
            end
            else if (cycle_strobe && rx_new_seq && !rx_busy && !rx_start)
            begin
                // The new counter value becomes the reference for the next one.
                module_rx_seq_mirror <= cpu_tx_seq_count;
                rx_window            <= cpu_to_module_window;
                rx_start             <= 1'b1;
            end
        end
    end

    // Input direction runs on its own sync state.
    assign next_header = {1'b1, 1'b0, 3'h0, tx_len};

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            module_tx_seq_count    <= '0;
            module_tx_sync_request <= 1'b0;
            module_to_cpu_window   <= '0;
        end
        else if (cycle_strobe)
        begin
            module_tx_sync_request <= tx_open;
            if (!tx_synced)
            begin
                module_tx_seq_count                <= '0;
                module_to_cpu_window               <= '0;
            end
            else if (tx_send)
            begin
                // Whole message in one segment; header at byte zero.
                module_to_cpu_window <= {tx_data, next_header};
                module_tx_seq_count  <= SEQ_W'(module_tx_seq_count + 1'b1);
            end
        end
    end

    ssc_deframer u_deframer (
        .clock    (clock),
        .rst_n    (rst_n),
        .start    (rx_start),
        .window   (rx_window),
        .flush    (rx_flush),
        .hold     (rx_ready || df_done),
        .busy     (rx_busy),
        .wr_en    (df_wr_en),
        .wr_addr  (df_wr_addr),
        .wr_data  (df_wr_data),
        .msg_done (df_done),
        .msg_len  (df_len)
    );

    ssc_msg_ram u_ram (
        .clock   (clock),
        .wr_en   (df_wr_en),
        .wr_addr (df_wr_addr),
        .wr_data (df_wr_data),
        .rd_addr (rx_index),
        .rd_data (ram_data)
    );

    // APB: one wait state, write applied at the edge that sees pready high.
    assign apb_access = psel && penable && !pready;
    assign apb_write  = psel && penable && pready && pwrite;

    always_comb
    begin
        mapped     = 1'b1;
        read_value = RESET_WORD;
        unique case (paddr)
            REG_CTRL:    read_value = {29'h0, 1'b0, tx_go, tx_open};
            REG_STATUS:
            begin
                read_value[STAT_RX_SYNC]                    = rx_synced;
                read_value[STAT_TX_SYNC]                    = tx_synced;
                read_value[STAT_RX_READY]                   = rx_ready;
                read_value[STAT_TX_BUSY]                    = tx_go;
                read_value[STAT_LEN_LSB +: MSG_LEN_W]       = rx_len;
                read_value[STAT_MOD_LSB +: 8]               = module_status_byte;
                read_value[STAT_CPU_LSB +: 8]               = cpu_status_byte;
            end
            REG_TX_LEN:  read_value = {29'h0, tx_len};
            REG_TX_LO:   read_value = tx_data[31:0];
            REG_TX_HI:   read_value = {16'h0, tx_data[47:32]};
            REG_RX_IDX:  read_value = {26'h0, rx_index};
            REG_RX_DATA: read_value = {24'h0, ram_data};
            default:     mapped     = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= RESET_WORD;
        end
        else
        begin
            pready  <= apb_access;
            pslverr <= apb_access && !mapped;
            if (apb_access && !pwrite)
            begin
                prdata <= read_value;
            end
        end
    end

    // Software registers.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_open  <= 1'b0;
            tx_go    <= 1'b0;
            tx_len   <= '0;
            tx_data  <= '0;
            rx_index <= '0;
        end
        else
        begin
            if (tx_send || (cycle_strobe && !tx_synced))
            begin
                tx_go <= 1'b0;
            end
            if (apb_write && mapped)
            begin
                unique case (paddr)
                    REG_CTRL:
                    begin
                        tx_open <= pwdata[CTRL_TX_OPEN];
                        if (pwdata[CTRL_TX_GO] && tx_len != '0)
                        begin
                            tx_go <= 1'b1;
                        end
                    end
                    REG_TX_LEN:
                    begin
                        // Segment with header must fit one window.
                        tx_len <= (pwdata[2:0] > MAX_SEG_LEN[2:0]) ? MAX_SEG_LEN[2:0] : pwdata[2:0];
                    end
                    REG_TX_LO:  tx_data[31:0]  <= pwdata;
                    REG_TX_HI:  tx_data[47:32] <= pwdata[15:0];
                    REG_RX_IDX: rx_index       <= pwdata[RAM_AW-1:0];
                    default:    ;
                endcase
            end
        end
    end

    // Received message flag; a completion wins over a software release.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_ready <= 1'b0;
            rx_len   <= '0;
        end
        else if (df_done)
        begin
            rx_ready <= 1'b1;
            rx_len   <= df_len;
        end
        else if (apb_write && paddr == REG_CTRL && pwdata[CTRL_RX_FREE])
        begin
            rx_ready <= 1'b0;
        end
    end

    default clocking cs_clk @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_rx_mirror_copy: assert property (cycle_strobe && !rx_synced |=>
        module_rx_seq_mirror == $past(cpu_tx_seq_count) && module_rx_sync_confirm == $past(cpu_tx_sync_request))
        else $error("closed output channel did not mirror the CPU status");
    chk_rx_ignore_closed: assert property (cycle_strobe && !rx_synced |=> !rx_start ##1 !rx_busy)
        else $error("window accepted while output channel closed");
    chk_rx_accept_seq: assert property (cycle_strobe && rx_synced && rx_new_seq && !rx_busy && !rx_start
        |=> rx_start && module_rx_seq_mirror == $past(cpu_tx_seq_count))
        else $error("new sequence not captured");
    chk_rx_no_repeat: assert property (cycle_strobe && rx_synced && !rx_new_seq |=> !rx_start)
        else $error("window accepted without a new counter value");
    chk_tx_closed_zero: assert property (cycle_strobe && !tx_synced |=>
        module_tx_seq_count == '0 && module_to_cpu_window[7:0] == IDLE_HEADER)
        else $error("closed input channel not idle");
    chk_tx_header: assert property (tx_send |=> module_to_cpu_window[CB_LAST_BIT]
        && module_to_cpu_window[CB_LEN_LSB +: LEN_W] == {3'h0, $past(tx_len)} && !tx_go)
        else $error("header byte not at position zero");
    chk_tx_seq_step: assert property (tx_send |=> module_tx_seq_count == SEQ_W'($past(module_tx_seq_count) + 1'b1))
        else $error("input counter did not step by one");
    chk_seg_fit: assert property (tx_len <= MAX_SEG_LEN[2:0])
        else $error("segment length exceeds window");
    chk_ready_sticky: assert property (rx_ready && !$past(df_done) && !apb_write |=> rx_ready)
        else $error("received message flag lost");

    cov_rx_window: cover property (rx_start ##[1:20] df_done);
    cov_tx_send: cover property (tx_send);
    cov_resync: cover property (rx_synced ##1 cycle_strobe && !cpu_tx_sync_request);
endmodule : ssc_channel_sync

// File: ssc_cpu_model.sv
`timescale 1ns/1ps
module ssc_cpu_model
    import ssc_pkg::*;
(
    // Clock
    input  wire logic                clock,
    // Values the CPU program wants on the bus
    input  wire logic [7:0]          req_status,
    input  wire logic [MTU_BITS-1:0] req_window,
    // Cyclic link
    output logic                     cycle_strobe = 1'h0,
    output logic      [7:0]          cpu_status_byte = 8'h00,
    output logic      [MTU_BITS-1:0] cpu_to_module_window = '0
);
    logic [3:0] phase = 4'h0;
    // New values are latched mid-cycle so they stand still around each strobe.
    always @(posedge clock)
    begin
        phase <= phase + 4'h1;
        cycle_strobe <= (phase == 4'hF);
        if (phase == 4'h8)
        begin
            cpu_status_byte <= req_status;
            cpu_to_module_window <= req_window;
        end
    end
endmodule : ssc_cpu_model

// File: ssc_deframer.sv
`timescale 1ns/1ps
module ssc_deframer
    import ssc_pkg::*;
(
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    // Window in
    input  wire logic                 start,
    input  wire logic [MTU_BITS-1:0]  window,
    input  wire logic                 flush,
    input  wire logic                 hold,
    output logic                      busy,
    // Message store
    output logic                      wr_en,
    output logic      [RAM_AW-1:0]    wr_addr,
    output logic      [7:0]           wr_data,
    output logic                      msg_done,
    output logic      [MSG_LEN_W-1:0] msg_len
);
    ssc_df_state_t          state;
    logic [MTU_BITS-1:0]    win;
    logic [POS_W-1:0]       pos;
    logic                   expect_cb;
    logic [LEN_W-1:0]       seg_left;
    logic                   seg_last;
    logic                   seg_next;
    logic [MSG_LEN_W-1:0]   count;
    logic [7:0]             cur;

    assign cur  = win[8*pos +: 8];
    assign busy = (state == DF_RUN);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= DF_IDLE;
            win       <= '0;
            pos       <= '0;
            expect_cb <= 1'b1;
            seg_left  <= '0;
            seg_last  <= 1'b0;
            seg_next  <= 1'b0;
            count     <= '0;
            wr_en     <= 1'b0;
            wr_addr   <= '0;
            wr_data   <= '0;
            msg_done  <= 1'b0;
            msg_len   <= '0;
        end
        else
        begin
            wr_en    <= 1'b0;
            msg_done <= 1'b0;
            if (flush)
            begin
                // A broken link throws away the partial message only.
                state     <= DF_IDLE;
                expect_cb <= 1'b1;
                count     <= '0;
            end
            else
            begin
                unique case (state)
                    DF_IDLE:
                    begin
                        if (start)
                        begin
                            win   <= window;
                            pos   <= '0;
                            state <= DF_RUN;
                        end
                    end
                    DF_RUN:
                    begin
                        if (!hold && expect_cb)
                        begin
                            seg_left <= cur[CB_LEN_LSB +: LEN_W];
                            seg_last <= cur[CB_LAST_BIT];
                            seg_next <= cur[CB_NEXT_BIT];
                            if (cur[CB_LEN_LSB +: LEN_W] == '0)
                            begin
                                // Idle or empty header: next header opens the next window.
                                if (cur[CB_LAST_BIT] && count != '0)
                                begin
                                    msg_done <= 1'b1;
                                    msg_len  <= count;
                                    count    <= '0;
                                end
                                state <= DF_IDLE;
                            end
                            else
                            begin
                                expect_cb <= 1'b0;
                                if (pos == LAST_POS)
                                begin
                                    state <= DF_IDLE;
                                end
                                pos <= POS_W'(pos + 1'b1);
                            end
                        end
                        else if (!hold)
                        begin
                            if (count < MSG_LEN_MAX)
                            begin
                                wr_en   <= 1'b1;
                                wr_addr <= count[RAM_AW-1:0];
                                wr_data <= cur;
                                count   <= MSG_LEN_W'(count + 1'b1);
                            end
                            seg_left <= LEN_W'(seg_left - 1'b1);
                            if (seg_left == 6'h01)
                            begin
                                // Header follows at position plus one plus length.
                                expect_cb <= 1'b1;
                                if (seg_last)
                                begin
                                    msg_done <= 1'b1;
                                    msg_len  <= (count < MSG_LEN_MAX) ? MSG_LEN_W'(count + 1'b1) : count;
                                    count    <= '0;
                                end
                                if (!seg_next || pos == LAST_POS)
                                begin
                                    state <= DF_IDLE;
                                end
                            end
                            else if (pos == LAST_POS)
                            begin
                                state <= DF_IDLE;
                            end
                            pos <= POS_W'(pos + 1'b1);
                        end
                    end
                endcase
            end
        end
    end

    default clocking df_clk @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_flush_clears: assert property (flush |=> !busy && !msg_done && count == '0)
        else $error("flush did not discard the partial message");
    chk_write_only_run: assert property (wr_en |-> $past(state) == DF_RUN && !$past(flush))
        else $error("message byte written outside a running window");
endmodule : ssc_deframer

// File: ssc_msg_ram.sv
`timescale 1ns/1ps
module ssc_msg_ram
    import ssc_pkg::*;
(
    // Clock
    input  wire logic              clock,
    // Write port
    input  wire logic              wr_en,
    input  wire logic [RAM_AW-1:0] wr_addr,
    input  wire logic [7:0]        wr_data,
    // Read port
    input  wire logic [RAM_AW-1:0] rd_addr,
    output logic      [7:0]        rd_data
);
    logic [7:0] mem [RAM_DEPTH];

    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : ssc_msg_ram

// File: ssc_pkg.sv
package ssc_pkg;

    localparam int MTU_BYTES    = 7;
    localparam int MTU_BITS     = MTU_BYTES * 8;
    localparam int SEQ_W        = 3;
    localparam int LEN_W        = 6;
    localparam int POS_W        = 3;
    localparam int RAM_AW       = 6;
    localparam int RAM_DEPTH    = 64;
    localparam int MSG_LEN_W    = 7;

    localparam logic [POS_W-1:0]     LAST_POS      = 3'h6;
    localparam logic [LEN_W-1:0]     MAX_SEG_LEN   = 6'h06;
    localparam logic [MSG_LEN_W-1:0] MSG_LEN_MAX   = 7'h40;
    localparam logic [7:0]           IDLE_HEADER   = 8'h00;

    localparam int CB_LEN_LSB   = 0;
    localparam int CB_NEXT_BIT  = 6;
    localparam int CB_LAST_BIT  = 7;

    localparam int ST_SEQ_LSB   = 0;
    localparam int ST_SYNC_BIT  = 3;
    localparam int ST_MIR_LSB   = 4;
    localparam int ST_CONF_BIT  = 7;

    localparam logic [11:0] REG_CTRL    = 12'h000;
    localparam logic [11:0] REG_STATUS  = 12'h004;
    localparam logic [11:0] REG_TX_LEN  = 12'h008;
    localparam logic [11:0] REG_TX_LO   = 12'h00C;
    localparam logic [11:0] REG_TX_HI   = 12'h010;
    localparam logic [11:0] REG_RX_IDX  = 12'h014;
    localparam logic [11:0] REG_RX_DATA = 12'h018;

    localparam int CTRL_TX_OPEN   = 0;
    localparam int CTRL_TX_GO     = 1;
    localparam int CTRL_RX_FREE   = 2;

    localparam int STAT_RX_SYNC   = 0;
    localparam int STAT_TX_SYNC   = 1;
    localparam int STAT_RX_READY  = 2;
    localparam int STAT_TX_BUSY   = 3;
    localparam int STAT_LEN_LSB   = 8;
    localparam int STAT_MOD_LSB   = 16;
    localparam int STAT_CPU_LSB   = 24;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic {DF_IDLE, DF_RUN} ssc_df_state_t;

endpackage : ssc_pkg

// File: tb.sv
`timescale 1ns/1ps
module tb;
    import ssc_pkg::*;
    logic                clock = 1'h0;
    logic                arst_n = 1'h0;
    logic                psel = 1'h0;
    logic                penable = 1'h0;
    logic                pwrite = 1'h0;
    logic [11:0]         paddr = 12'h000;
    logic [31:0]         pwdata = 32'h0;
    logic [31:0]         prdata, rd;
    logic                pready, pslverr, err, strobe;
    logic [7:0]          req_st = 8'h00, cpu_st, mod_st;
    logic [MTU_BITS-1:0] req_win = '0, cpu_win, mod_win;
    int                  miscompares = 0;
    int                  n_tests = 0;

    initial forever #4 clock = ~clock;

    ssc_cpu_model i_cpu (.clock(clock), .req_status(req_st), .req_window(req_win), .cycle_strobe(strobe),
        .cpu_status_byte(cpu_st), .cpu_to_module_window(cpu_win));
    ssc_channel_sync i_dut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cycle_strobe(strobe), .cpu_status_byte(cpu_st), .cpu_to_module_window(cpu_win),
        .module_status_byte(mod_st), .module_to_cpu_window(mod_win));

    task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do @(posedge clock); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task link(input logic [7:0] st, input logic [MTU_BITS-1:0] win);
        req_st <= st;
        req_win <= win;
        repeat (2) @(posedge clock iff strobe);
        repeat (10) @(posedge clock);
    endtask : link

    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (20000) @(posedge clock);
        miscompares++;
        print_verdict;
    end

    initial
    begin
        repeat (5) @(posedge clock);
        arst_n <= 1'h1;
        repeat (3) @(posedge clock);
        chk("status byte", mod_st, 32'h0);
        chk("idle header", mod_win[7:0], 32'h0);
        link(8'h00, 56'h81);
        chk("mirror", mod_st[7:4], 32'h0);
        apb(1'h0, REG_STATUS, 32'h0);
        chk("rx ready", rd[STAT_RX_READY], 32'h0);
        link(8'h08, 56'h81);
        chk("confirm", mod_st[7:4], 32'h8);
        link(8'h09, 56'hBBAA82);
        chk("mirror", mod_st[7:4], 32'h9);
        apb(1'h0, REG_STATUS, 32'h0);
        chk("msg len", rd[14:8], 32'h2);
        apb(1'h1, REG_CTRL, 32'h4);
        link(8'h0A, 56'h5501);
        link(8'h02, 56'h0);
        chk("confirm", mod_st[7], 32'h0);
        link(8'h08, 56'h0);
        link(8'h09, 56'h5A81);
        apb(1'h0, REG_STATUS, 32'h0);
        chk("msg len", rd[14:8], 32'h1);
        apb(1'h1, REG_RX_IDX, 32'h0);
        apb(1'h0, REG_RX_DATA, 32'h0);
        chk("rx data", rd, 32'h5A);
        apb(1'h0, 12'hFFC, 32'h0);
        chk("slave error", err, 32'h1);
        apb(1'h1, REG_CTRL, 32'h1);
        link(8'h89, 56'h0);
        chk("tx sync", mod_st[3:0], 32'h8);
        apb(1'h0, REG_STATUS, 32'h0);
        chk("sync flags", rd[1:0], 32'h3);
        apb(1'h1, REG_TX_LO, 32'h44332211);
        apb(1'h1, REG_TX_HI, 32'h00006655);
        apb(1'h1, REG_TX_LEN, 32'h7);
        apb(1'h0, REG_TX_LEN, 32'h0);
        chk("len clamp", rd, 32'h6);
        apb(1'h1, REG_TX_LEN, 32'h2);
        apb(1'h1, REG_CTRL, 32'h3);
        link(8'h89, 56'h0);
        chk("tx window", mod_win[23:0], 32'h221182);
        chk("tx payload", mod_win[55:24], 32'h66554433);
        chk("tx count", mod_st[3:0], 32'h9);
        apb(1'h0, REG_CTRL, 32'h0);
        chk("go cleared", rd, 32'h1);
        print_verdict;
    end
endmodule : tb
